//--- rtl/serial_host_master.sv
// two-wire bus master that writes to and reads from an audio decoder port
//
// Contract
// - data bit is valid at serial clock rise; change it only while low.
// - every transfer opens with data falling while clock is high.
// - write frame sends 7-bit address then direction bit low.
// - after the address byte the host clocks one acknowledge period.
// - write data goes msb first, one acknowledge period per byte.
// - same write frame for one byte, word or image; whole bytes only.
// - after the last written byte is acknowledged, host sends stop.
// - resend an unacknowledged byte; two misses in a row reset device.
// - request low makes host read: start, address, direction bit high.
// - after the read address byte the decoder returns an acknowledge.
// - host keeps reading whole bytes while the request line stays low.
// - host acknowledges each read byte by holding data low one period.
`timescale 1ns/1ps
`default_nettype none
module serial_host_master #(
  parameter int DEPTH = host_serial_pkg::FIFO_DEPTH,
  parameter int RESET_CYCLES = host_serial_pkg::DEV_RESET_CYCLES
) (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic [host_serial_pkg::ADDR_W-1:0] target_addr_in,
  input wire logic wr_valid_in,
  input wire logic [host_serial_pkg::DATA_W-1:0] wr_data_in,
  input wire logic wr_last_in,
  output logic wr_ready_out,
  output logic [host_serial_pkg::DATA_W-1:0] rd_data_out,
  output logic rd_valid_out,
  output logic host_serial_clock_out,
  input wire logic host_serial_data_io_in,
  output logic host_serial_data_io_out,
  output logic host_serial_data_io_oe_out,
  input wire logic read_request_n_in,
  output logic device_reset_out,
  output logic busy_out
);
  import host_serial_pkg::*;

  // ************************************************************
  // declarations
  // ************************************************************
  seq_state_t state;
  logic [7:0] qcnt;
  logic [1:0] phase;
  logic [3:0] bitn;
  logic [DATA_W-1:0] sh;
  logic [DATA_W-1:0] cur;
  logic is_read;
  logic is_addr;
  logic last_byte;
  logic [1:0] nack_cnt;
  logic reset_after_stop;
  logic [15:0] rst_cnt;
  logic [1:0] sda_sync;
  logic [1:0] req_sync;
  logic sda_s;
  logic req_n_s;
  logic tick;
  logic sending;
  logic fifo_valid;
  logic fifo_ready;
  logic [FIFO_W-1:0] fifo_data;

  // ************************************************************
  // write path buffer
  // ************************************************************
  write_fifo #(
    .WIDTH(FIFO_W),
    .DEPTH(DEPTH)
  ) u_fifo (
    .clk_sys_in(clk_sys_in),
    .rst_in(rst_in),
    .in_valid_in(wr_valid_in),
    .in_data_in({wr_last_in, wr_data_in}),
    .in_ready_out(wr_ready_out),
    .out_valid_out(fifo_valid),
    .out_data_out(fifo_data),
    .out_ready_in(fifo_ready)
  );

  // the sequencer pops only while parked with the clock low
  assign fifo_ready = (state == ST_LOAD);

  // ************************************************************
  // pin synchronisers
  // ************************************************************
  // both pins come from the decoder's side, two flops before any use
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      sda_sync <= 2'h3;
      req_sync <= 2'h3;
    end else begin
      sda_sync <= {sda_sync[0], host_serial_data_io_in};
      req_sync <= {req_sync[0], read_request_n_in};
    end
  end
  assign sda_s = sda_sync[1];
  assign req_n_s = req_sync[1];

  // ************************************************************
  // quarter-bit timebase
  // ************************************************************
  // the host makes the serial clock by dividing its own clock
  assign tick = (qcnt == QUARTER_CYCLES - 8'h01);
  always_ff @(posedge clk_sys_in) begin
    if (rst_in || state == ST_IDLE || state == ST_LOAD ||
        state == ST_RESET || tick) begin
      qcnt <= 8'h00;
    end else begin
      qcnt <= qcnt + 8'h01;
    end
  end

  // address and write bytes are sent, read bytes are received
  assign sending = !(is_read && !is_addr);

  // pin is open drain, the host only ever pulls it low
  always_ff @(posedge clk_sys_in) begin
    host_serial_data_io_out <= 1'b0;
  end

  // ************************************************************
  // frame sequencer
  // ************************************************************
  // a write byte is resent once on a miss; a repeated miss ends the
  // frame and pulses the decoder reset rather than looping forever
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      state <= ST_IDLE;
      phase <= 2'h0;
      bitn <= 4'h0;
      sh <= '0;
      cur <= '0;
      is_read <= 1'b0;
      is_addr <= 1'b0;
      last_byte <= 1'b0;
      nack_cnt <= 2'h0;
      reset_after_stop <= 1'b0;
      rst_cnt <= 16'h0000;
      host_serial_clock_out <= 1'b1;
      host_serial_data_io_oe_out <= 1'b0;
      rd_data_out <= '0;
      rd_valid_out <= 1'b0;
      device_reset_out <= 1'b0;
      busy_out <= 1'b0;
    end else begin
      rd_valid_out <= 1'b0;
      case (state)
        ST_IDLE: begin
          host_serial_clock_out <= 1'b1;
          host_serial_data_io_oe_out <= 1'b0;
          phase <= 2'h0;
          nack_cnt <= 2'h0;
          // pending responses are drained before new writes go out
          if (!req_n_s) begin
            is_read <= 1'b1;
            is_addr <= 1'b1;
            cur <= {target_addr_in, RW_READ};
            busy_out <= 1'b1;
            state <= ST_START;
          end else if (fifo_valid) begin
            is_read <= 1'b0;
            is_addr <= 1'b1;
            cur <= {target_addr_in, RW_WRITE};
            busy_out <= 1'b1;
            state <= ST_START;
          end else begin
            busy_out <= 1'b0;
          end
        end
        ST_START: begin
          if (tick) begin
            phase <= phase + 2'h1;
            if (phase == 2'h1) begin
              host_serial_data_io_oe_out <= 1'b1;
            end else if (phase == 2'h3) begin
              host_serial_clock_out <= 1'b0;
              sh <= cur;
              bitn <= 4'h0;
              host_serial_data_io_oe_out <= ~cur[7];
              state <= ST_BIT;
            end
          end
        end
        ST_BIT: begin
          if (tick) begin
            phase <= phase + 2'h1;
            if (phase == 2'h1) begin
              host_serial_clock_out <= 1'b1;
            end else if (phase == 2'h3) begin
              // sample late in the high half, after the synchroniser
              host_serial_clock_out <= 1'b0;
              if (bitn != ACK_BIT) begin
                sh <= {sh[6:0], sda_s};
                bitn <= bitn + 4'h1;
                if (bitn == LAST_DATA_BIT) begin
                  // acknowledge slot: receiver of the byte pulls low
                  host_serial_data_io_oe_out <= !sending;
                  if (!sending) begin
                    rd_data_out <= {sh[6:0], sda_s};
                    rd_valid_out <= 1'b1;
                  end
                end else begin
                  host_serial_data_io_oe_out <= sending && !sh[6];
                end
              end else if (!sending) begin
                // request is settled by the acknowledge rise
                if (req_n_s) begin
                  host_serial_data_io_oe_out <= 1'b1;
                  state <= ST_STOP;
                end else begin
                  bitn <= 4'h0;
                  host_serial_data_io_oe_out <= 1'b0;
                end
              end else if (sda_s) begin
                // missed acknowledge on an address or write byte
                if (nack_cnt + 2'h1 == NACK_LIMIT) begin
                  reset_after_stop <= 1'b1;
                  host_serial_data_io_oe_out <= 1'b1;
                  state <= ST_STOP;
                end else begin
                  nack_cnt <= nack_cnt + 2'h1;
                  sh <= cur;
                  bitn <= 4'h0;
                  host_serial_data_io_oe_out <= ~cur[7];
                end
              end else begin
                nack_cnt <= 2'h0;
                is_addr <= 1'b0;
                if (is_addr && is_read) begin
                  bitn <= 4'h0;
                  host_serial_data_io_oe_out <= 1'b0;
                end else if (!is_addr && last_byte) begin
                  host_serial_data_io_oe_out <= 1'b1;
                  state <= ST_STOP;
                end else begin
                  host_serial_data_io_oe_out <= 1'b0;
                  state <= ST_LOAD;
                end
              end
            end
          end
        end
        ST_LOAD: begin
          // clock parks low until the next whole byte is buffered
          phase <= 2'h0;
          if (fifo_valid) begin
            cur <= fifo_data[DATA_W-1:0];
            sh <= fifo_data[DATA_W-1:0];
            last_byte <= fifo_data[DATA_W];
            bitn <= 4'h0;
            host_serial_data_io_oe_out <= ~fifo_data[7];
            state <= ST_BIT;
          end
        end
        ST_STOP: begin
          if (tick) begin
            phase <= phase + 2'h1;
            if (phase == 2'h1) begin
              host_serial_clock_out <= 1'b1;
            end else if (phase == 2'h2) begin
              host_serial_data_io_oe_out <= 1'b0;
            end else if (phase == 2'h3) begin
              if (reset_after_stop) begin
                reset_after_stop <= 1'b0;
                device_reset_out <= 1'b1;
                rst_cnt <= 16'h0000;
                state <= ST_RESET;
              end else begin
                state <= ST_IDLE;
              end
            end
          end
        end
        ST_RESET: begin
          // decoder address returns to zero, so target must follow
          rst_cnt <= rst_cnt + 16'h0001;
          if (rst_cnt == 16'(RESET_CYCLES - 1)) begin
            device_reset_out <= 1'b0;
            state <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end
endmodule // serial_host_master
`default_nettype wire

//--- rtl/host_serial_pkg.sv
// constants shared by the two-wire host controller and its write FIFO
package host_serial_pkg;
  // ************************************************************
  // widths
  // ************************************************************
  localparam int ADDR_W = 7;
  localparam int DATA_W = 8;
  localparam int FIFO_W = DATA_W + 1;
  localparam int FIFO_DEPTH = 4;
  // ************************************************************
  // address and direction
  // ************************************************************
  localparam logic [ADDR_W-1:0] DEV_ADDR_RESET = 7'h00;
  localparam logic RW_WRITE = 1'b0;
  localparam logic RW_READ = 1'b1;
  localparam logic [1:0] NACK_LIMIT = 2'h2;
  localparam logic [3:0] ACK_BIT = 4'h8;
  localparam logic [3:0] LAST_DATA_BIT = 4'h7;
  // ************************************************************
  // timing
  // ************************************************************
  localparam int SYS_PERIOD_NS = 100;
  localparam int LINK_PERIOD_NS = 800;
  localparam logic [7:0] QUARTER_CYCLES =
    8'(LINK_PERIOD_NS / (4 * SYS_PERIOD_NS));
  localparam int DEV_RESET_NS = 2000;
  localparam int DEV_RESET_CYCLES = DEV_RESET_NS / SYS_PERIOD_NS;
  // ************************************************************
  // sequencer states
  // ************************************************************
  typedef enum logic [2:0] {
    ST_IDLE, ST_START, ST_BIT, ST_LOAD, ST_STOP, ST_RESET
  } seq_state_t;
endpackage

//--- rtl/write_fifo.sv
// small flip-flop FIFO carrying write bytes toward the serial sequencer
`timescale 1ns/1ps
`default_nettype none
module write_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 4
) (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic in_valid_in,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic in_ready_out,
  output logic out_valid_out,
  output logic [WIDTH-1:0] out_data_out,
  input wire logic out_ready_in
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wr_ptr;
  logic [PW-1:0] rd_ptr;
  logic [PW:0] count;
  logic [PW:0] next_count;
  logic push;
  logic pop;

  // ************************************************************
  // handshakes
  // ************************************************************
  assign push = in_valid_in && in_ready_out;
  assign pop = out_valid_out && out_ready_in;
  assign out_valid_out = (count != '0);
  assign out_data_out = mem[rd_ptr];

  // occupancy after this cycle's push and pop
  always_comb begin
    next_count = count;
    if (push && !pop) begin
      next_count = count + 1'b1;
    end else if (pop && !push) begin
      next_count = count - 1'b1;
    end
  end

  // ready is registered so the top sees a flop, costing no throughput
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      count <= '0;
      in_ready_out <= 1'b1;
    end else begin
      count <= next_count;
      in_ready_out <= (next_count != (PW+1)'(DEPTH));
    end
  end

  // pointers wrap on the power-of-two depth
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end

  // storage needs no reset, it is read only when counted valid
  always_ff @(posedge clk_sys_in) begin
    if (push) begin
      mem[wr_ptr] <= in_data_in;
    end
  end
endmodule // write_fifo
`default_nettype wire

//--- verif/serial_host_master_properties.sv
// port assertions for the two-wire host controller
`timescale 1ns/1ps
`default_nettype none
module serial_host_master_checker
  import host_serial_pkg::*;
#(
  parameter int RESET_CYCLES = 20
) (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic [host_serial_pkg::ADDR_W-1:0] target_addr_in,
  input wire logic host_serial_clock_out,
  input wire logic host_serial_data_io_oe_out,
  input wire logic device_reset_out,
  input wire logic busy_out
);
  logic scl;
  logic oe;
  logic scl_q;
  logic oe_q;
  logic first;
  logic dir_rd;
  logic [3:0] nrise;
  logic [7:0] ash;
  int unsigned hi_cnt;
  assign scl = host_serial_clock_out;
  assign oe = host_serial_data_io_oe_out;
  // rises within a byte; the ninth rise closes the ack slot
  always_ff @(posedge clk_sys_in) begin
    scl_q <= rst_in ? 1'h1 : scl;
    oe_q <= rst_in ? 1'h0 : oe;
    // a start reopens the count; busy stays high across a retry frame
    if (rst_in || !busy_out || (scl && scl_q && oe && !oe_q)) begin
      nrise <= 4'h0;
      first <= 1'h1;
    end else if (scl && !scl_q) begin
      nrise <= (nrise == 4'h8) ? 4'h0 : nrise + 4'h1;
      if (nrise == 4'h8)
        first <= 1'h0;
      if (nrise < 4'h8)
        ash <= {ash[6:0], !oe};
      if (first && nrise == 4'h7)
        dir_rd <= !oe;
    end
  end
  // counts how long the device reset has been held
  always_ff @(posedge clk_sys_in) begin
    if (rst_in || !device_reset_out)
      hi_cnt <= 0;
    else
      hi_cnt <= hi_cnt + 1;
  end
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);
  property p_idle;
    !busy_out && !device_reset_out |-> scl && !oe;
  endproperty
  a_idle: assert property (p_idle)
    else $error("lines not idle outside a frame");
  property p_start;
    $rose(busy_out) |-> scl && !oe ##[1:6] scl && oe;
  endproperty
  a_start: assert property (p_start)
    else $error("frame did not open with a start");
  property p_stable_high;
    scl && $past(scl) && nrise > 4'h1 |-> $stable(oe);
  endproperty
  a_stable_high: assert property (p_stable_high)
    else $error("data moved while clock high");
  property p_stop;
    $fell(oe) && scl && $past(scl) |-> ##[1:6] (!busy_out || device_reset_out);
  endproperty
  a_stop: assert property (p_stop)
    else $error("data rise with clock high did not end the frame");
  property p_reset_len;
    $fell(device_reset_out) |-> hi_cnt == RESET_CYCLES;
  endproperty
  a_reset_len: assert property (p_reset_len)
    else $error("device reset length wrong");
  property p_addr;
    first && nrise == 4'h8 |-> ash[7:1] == target_addr_in;
  endproperty
  a_addr: assert property (p_addr)
    else $error("address bits differ from target");
  property p_ack_free;
    nrise == 4'h8 && !scl && !$past(scl) && (first || !dir_rd) |-> !oe;
  endproperty
  a_ack_free: assert property (p_ack_free)
    else $error("host drove data in device ack slot");
  property p_ack_read;
    nrise == 4'h8 && !scl && !$past(scl) && !first && dir_rd |-> oe;
  endproperty
  a_ack_read: assert property (p_ack_read)
    else $error("host did not ack a read byte");
endmodule // serial_host_master_checker
bind serial_host_master serial_host_master_checker #(
  .RESET_CYCLES(RESET_CYCLES)
) u_serial_host_master_checker (
  .clk_sys_in(clk_sys_in),
  .rst_in(rst_in),
  .target_addr_in(target_addr_in),
  .host_serial_clock_out(host_serial_clock_out),
  .host_serial_data_io_oe_out(host_serial_data_io_oe_out),
  .device_reset_out(device_reset_out),
  .busy_out(busy_out)
);
`default_nettype wire

//--- verif/dev_model.sv
// behavioural decoder serial port on the far side of the host
`timescale 1ns/1ps
`default_nettype none
module dev_model (
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic dev_reset_in,
  output logic sda_low_out,
  output logic read_request_n_out
);
  logic [6:0] own_addr = 7'h00;
  logic check_off = 1'h0;
  logic sel = 1'h0;
  logic rd = 1'h0;
  logic in_addr = 1'h0;
  logic acked = 1'h0;
  logic sending = 1'h0;
  logic [7:0] sh;
  logic [7:0] tx;
  logic [7:0] rd_q[$];
  logic [7:0] rx_q[$];
  int cnt = 0;
  int refuse_n = 0;
  initial sda_low_out = 1'h0;
  initial read_request_n_out = 1'h1;
  always @(posedge dev_reset_in) own_addr = 7'h00;
  // queue a response; the request line goes low at once
  task automatic give(input logic [7:0] b);
    rd_q.push_back(b);
    read_request_n_out = 1'h0;
  endtask
  // start or stop; settle first so a clock fall at the same time wins
  always @(sda_in) begin
    #1;
    if (scl_in) begin
      cnt = 0;
      in_addr = !sda_in;
      sel = 1'h0;
      sending = 1'h0;
    end
  end
  // capture on the rise; drop the request after the last bit if drained
  always @(posedge scl_in) begin
    if (cnt < 8)
      sh = {sh[6:0], sda_in};
    cnt++;
    if (sending && cnt == 8 && rd_q.size() == 0)
      read_request_n_out = 1'h1;
  end
  // all data line changes happen on the clock fall; the request line is dropped on the rise
  always @(negedge scl_in) begin
    sda_low_out = 1'h0;
    if (cnt == 8) begin
      if (in_addr) begin
        sel = check_off || sh[7:1] == own_addr;
        rd = sh[0];
      end
      acked = sel && (in_addr || !rd) && refuse_n == 0;
      if (sel && refuse_n > 0)
        refuse_n--;
      if (acked && !in_addr)
        rx_q.push_back(sh);
      sda_low_out = acked;
    end else if (cnt == 9) begin
      cnt = 0;
      if (acked)
        in_addr = 1'h0;
      sending = !in_addr && sel && rd && rd_q.size() > 0;
      if (sending)
        tx = rd_q.pop_front();
    end
    if (sending && cnt < 8)
      sda_low_out = !tx[7 - cnt];
  end
endmodule // dev_model
`default_nettype wire

//--- verif/test_serial_host_master.sv
// self-checking bench for the two-wire host controller
`timescale 1ns/1ps
`default_nettype none
module test_serial_host_master;
  import host_serial_pkg::*;
  localparam int RST_CYC = 4;
  logic clk_sys_in = 1'h0;
  logic rst_in = 1'h1;
  logic [ADDR_W-1:0] target_addr = 7'h00;
  logic wr_valid = 1'h0;
  logic wr_last = 1'h0;
  logic [DATA_W-1:0] wr_data = 8'h00;
  logic [DATA_W-1:0] rd_data;
  logic wr_ready, rd_valid, scl, sda, d_out, oe, req_n, dev_rst, busy, dev_low;
  int mismatches = 0;
  int cmp_count = 0;
  int stalls = 0;
  int rst_seen = 0;
  always #50 clk_sys_in = !clk_sys_in;
  // pulled-up wire: low when either side pulls it
  assign sda = (oe ? d_out : 1'h1) & !dev_low;
  always @(posedge clk_sys_in) if (dev_rst === 1'h1) rst_seen++;
  serial_host_master #(.RESET_CYCLES(RST_CYC)) u_serial_host_master (
    .clk_sys_in(clk_sys_in), .rst_in(rst_in), .target_addr_in(target_addr),
    .wr_valid_in(wr_valid), .wr_data_in(wr_data), .wr_last_in(wr_last),
    .wr_ready_out(wr_ready), .rd_data_out(rd_data), .rd_valid_out(rd_valid),
    .host_serial_clock_out(scl), .host_serial_data_io_in(sda),
    .host_serial_data_io_out(d_out), .host_serial_data_io_oe_out(oe),
    .read_request_n_in(req_n), .device_reset_out(dev_rst), .busy_out(busy));
  dev_model u_dev_model (.scl_in(scl), .sda_in(sda), .dev_reset_in(dev_rst),
    .sda_low_out(dev_low), .read_request_n_out(req_n));
  task automatic check(input logic [7:0] seen, exp, input string what);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // one byte offered and held until taken; refusals are counted
  task automatic send(input logic [7:0] d, input logic l);
    wr_valid <= 1'h1;
    wr_data <= d;
    wr_last <= l;
    @(posedge clk_sys_in);
    while (wr_ready !== 1'h1) begin
      stalls++;
      @(posedge clk_sys_in);
    end
  endtask
  // frame end: busy must fall within the limit
  task automatic wait_idle();
    int n;
    n = 0;
    repeat (6) @(posedge clk_sys_in);
    while (busy !== 1'h0 && n < 20000) begin
      n++;
      @(posedge clk_sys_in);
    end
    check(n < 20000, 1'h1, "frame end");
  endtask
  task automatic write_frame(input logic [6:0] a, input logic [7:0] b[$]);
    target_addr <= a;
    foreach (b[i]) send(b[i], i == b.size() - 1);
    wr_valid <= 1'h0;
    wait_idle();
  endtask
  task automatic expect_rx(input logic [7:0] b[$]);
    check(u_dev_model.rx_q.size(), b.size(), "byte count");
    foreach (b[i]) check(u_dev_model.rx_q[i], b[i], "byte");
    u_dev_model.rx_q.delete();
  endtask
  task automatic t_reset_state();
    check(scl, 1'h1, "clock idle");
    check(oe, 1'h0, "data idle");
    check(d_out, 1'h0, "open drain level");
    $display("test reset_state done");
  endtask
  // fifo overfilled while the far side refuses the first address
  task automatic t_burst();
    u_dev_model.refuse_n = 1;
    write_frame(7'h00, {8'hA5, 8'h3C, 8'h81, 8'h5A, 8'hF0, 8'h01, 8'h7E});
    check(stalls > 0, 1'h1, "fifo refused");
    check(wr_ready, 1'h1, "fifo drained");
    expect_rx({8'hA5, 8'h3C, 8'h81, 8'h5A, 8'hF0, 8'h01, 8'h7E});
    $display("test burst done");
  endtask
  task automatic t_read();
    logic [7:0] exp[$];
    int n;
    int k;
    exp = {8'h5A, 8'hC3, 8'h0F};
    foreach (exp[i]) u_dev_model.give(exp[i]);
    k = 0;
    for (n = 0; n < 3000 && !(n > 10 && busy === 1'h0); n++) begin
      @(posedge clk_sys_in);
      if (rd_valid === 1'h1) begin
        check(rd_data, exp[k % 3], "read byte");
        k++;
      end
    end
    check(k, 3, "read count");
    check(req_n, 1'h1, "request released");
    $display("test read done");
  endtask
  task automatic t_addr_config();
    u_dev_model.own_addr = 7'h15;
    write_frame(7'h15, {8'h42});
    expect_rx({8'h42});
    u_dev_model.check_off = 1'h1;
    write_frame(7'h6A, {8'h24});
    expect_rx({8'h24});
    u_dev_model.check_off = 1'h0;
    $display("test addr_config done");
  endtask
  // two misses in a row reset the decoder; its address falls back to zero,
  // so the byte still queued goes out once the target follows
  task automatic t_wrong_addr();
    int n;
    u_dev_model.own_addr = 7'h15;
    target_addr <= 7'h33;
    send(8'h11, 1'h1);
    wr_valid <= 1'h0;
    n = 0;
    while (dev_rst !== 1'h1 && n < 20000) begin
      n++;
      @(posedge clk_sys_in);
    end
    check(n < 20000, 1'h1, "device reset");
    check(u_dev_model.rx_q.size(), 0, "ignored frame");
    target_addr <= 7'h00;
    wait_idle();
    check(rst_seen, RST_CYC, "device reset cycles");
    expect_rx({8'h11});
    $display("test wrong_addr done");
  endtask
  // limit well above the roughly two thousand cycles the tests need
  initial begin
    repeat (40000) @(posedge clk_sys_in);
    mismatches++;
    tally_and_finish();
  end
  initial begin
    repeat (5) @(posedge clk_sys_in);
    rst_in <= 1'h0;
    repeat (3) @(posedge clk_sys_in);
    t_reset_state();
    t_burst();
    t_read();
    t_addr_config();
    t_wrong_addr();
    tally_and_finish();
  end
endmodule // test_serial_host_master
`default_nettype wire
